// *** logic/rtsq_defines.svh ***
// timing counts, widths and reset values of the reset sequencer
// assumes a 125 MHz system clock and inclusion by bare name
`ifndef RTSQ_DEFINES_SVH
`define RTSQ_DEFINES_SVH

`define RTSQ_CLK_MHZ 125
`define RTSQ_POWERUP_DELAY_TIMER_MS 72
`define RTSQ_POWERUP_DELAY_TIMER_CYC (`RTSQ_POWERUP_DELAY_TIMER_MS * 1000 * `RTSQ_CLK_MHZ)
`define RTSQ_POWERUP_DELAY_TIMER_W 24
`define RTSQ_OST_CYC 11'h400
`define RTSQ_OST_W 11
`define RTSQ_MASTER_CLEAR_N_FILT_NS 200
`define RTSQ_MASTER_CLEAR_N_FILT_CYC \
  ((`RTSQ_MASTER_CLEAR_N_FILT_NS * `RTSQ_CLK_MHZ + 999) / 1000)
`define RTSQ_BOD_MIN_NS 100
`define RTSQ_BOD_MIN_CYC \
  ((`RTSQ_BOD_MIN_NS * `RTSQ_CLK_MHZ + 999) / 1000)
`define RTSQ_FILT_W 8
`define RTSQ_TO_RST 1'b1
`define RTSQ_PD_RST 1'b1
`define RTSQ_POR_FLAG_RST 1'b0

`endif

// *** logic/rtsq_pkg.sv ***
// types of the reset and time-out sequencer
// assumes nothing beyond the defines header
package rtsq_pkg;

  typedef enum logic [2:0] {
    RTSQ_SLOW_CRYSTAL = 3'h0,
    RTSQ_MID_CRYSTAL = 3'h1,
    RTSQ_FAST_CRYSTAL = 3'h2,
    RTSQ_EXT_CLOCK_IN = 3'h3,
    RTSQ_INTERNAL_OSC_IO = 3'h4,
    RTSQ_INTERNAL_OSC_DIVIDED_CLOCK_OUT = 3'h5,
    RTSQ_RC_OSC_IO = 3'h6,
    RTSQ_RC_OSC_DIVIDED_CLOCK_OUT = 3'h7
  } rtsq_osc_mode_t;

  // fixed configuration bits
  typedef struct packed {
    logic brownout_enable_cfg;
    logic ext_reset_pin_select;
    logic powerup_delay_cfg;
    rtsq_osc_mode_t osc_mode;
  } rtsq_cfg_t;

  // one-hot record of the last reset cause
  typedef struct packed {
    logic power_on;
    logic wdt_run;
    logic wdt_sleep;
    logic pin_run;
    logic pin_sleep;
    logic brownout;
  } rtsq_cause_t;

  typedef enum logic [4:0] {
    RTSQ_ST_RUN = 5'h01,
    RTSQ_ST_HOLD = 5'h02,
    RTSQ_ST_POWERUP_DELAY_TIMER = 5'h04,
    RTSQ_ST_OST = 5'h08,
    RTSQ_ST_PIN = 5'h10
  } rtsq_state_t;

endpackage

// *** logic/rtsq_sequencer.sv ***
// reset merge, power-up delay, oscillator start-up count, clock out
// assumes all inputs synchronous to CLK_IN; RST_N_IN is the power-on pulse
`timescale 1ns/1ns
`include "rtsq_defines.svh"

// Contract
// - clock-out pin gives clock divided by four
// - six reset causes are told apart
// - reset-insensitive registers see no reset here
// - other registers reset on every real reset
// - watchdog wake from sleep resets nothing
// - expired and sleep flags mark reset cause
// - reset pin filtered against short pulses
// - watchdog reset never drives the pin
// - config chooses pin or internal inactive tie
// - select one means pin, zero means I/O
// - power-on holds reset until supply good
// - falling supply never re-triggers power-on
// - 72 ms delay after power-on or brown-out
// - delay config set disables the delay
// - 1024 oscillator cycles after the delay
// - start-up count: crystal modes, power-on, wake
// - brown-out config bit enables detection
// - brown-out resets after minimum duration
// - hold below release level, then delay
// - dip during delay restarts the delay
// - delay then start-up count; none in ext-clock
// - time-outs run regardless of reset pin
// - power-on flag cleared only by power-on
module rtsq_sequencer #(
  parameter int POWERUP_CYCLES = `RTSQ_POWERUP_DELAY_TIMER_CYC
) (
  // clock, reset, enable
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  // configuration
  input wire rtsq_pkg::rtsq_cfg_t CFG_IN,
  // pins and monitors
  input wire logic MASTER_CLEAR_N_IN,
  input wire logic SUPPLY_GOOD_IN,
  input wire logic BROWNOUT_LOW_IN,
  input wire logic ABOVE_RELEASE_IN,
  input wire logic OSC_INPUT_IN,
  // core events
  input wire logic WDT_EXPIRE_IN,
  input wire logic SLEEP_IN,
  input wire logic POR_FLAG_SET_IN,
  // reset and status
  output logic CORE_RESET_N_OUT,
  output logic WAKE_RESUME_OUT,
  output rtsq_pkg::rtsq_cause_t RESET_CAUSE_OUT,
  output logic WATCHDOG_EXPIRED_FLAG_OUT,
  output logic SLEEP_ENTERED_FLAG_OUT,
  output logic POWER_ON_FLAG_OUT,
  // divided clock pin
  output logic DIVIDED_CLOCK_OUT,
  output logic DIVIDED_CLOCK_OE_OUT
);

  localparam logic [`RTSQ_FILT_W-1:0] MASTER_CLEAR_N_FILT =
    `RTSQ_FILT_W'(`RTSQ_MASTER_CLEAR_N_FILT_CYC);
  localparam logic [`RTSQ_FILT_W-1:0] BOD_MIN =
    `RTSQ_FILT_W'(`RTSQ_BOD_MIN_CYC);
  localparam logic [`RTSQ_POWERUP_DELAY_TIMER_W-1:0] POWERUP_DELAY_TIMER_LAST =
    `RTSQ_POWERUP_DELAY_TIMER_W'(POWERUP_CYCLES - 1);
  localparam logic [`RTSQ_OST_W-1:0] OST_LAST = `RTSQ_OST_CYC - 11'h001;

  function automatic logic [`RTSQ_FILT_W-1:0] filt_step(
    input logic active, input logic [`RTSQ_FILT_W-1:0] cnt,
    input logic [`RTSQ_FILT_W-1:0] lim);
    if (!active) filt_step = '0;
    else if (cnt >= lim) filt_step = lim;
    else filt_step = cnt + `RTSQ_FILT_W'(1);
  endfunction

  function automatic logic is_crystal(input rtsq_pkg::rtsq_osc_mode_t m);
    is_crystal = (m == rtsq_pkg::RTSQ_SLOW_CRYSTAL) ||
                 (m == rtsq_pkg::RTSQ_MID_CRYSTAL) ||
                 (m == rtsq_pkg::RTSQ_FAST_CRYSTAL);
  endfunction

  // filters and level trackers
  logic [`RTSQ_FILT_W-1:0] master_clear_n_cnt_reg, master_clear_n_cnt_next;
  logic [`RTSQ_FILT_W-1:0] bod_cnt_reg, bod_cnt_next;
  logic master_clear_n_low_reg, master_clear_n_low_next;
  logic bod_trip_reg, bod_trip_next;
  logic por_seen_reg, por_seen_next;
  logic osc_prev_reg, osc_prev_next;
  logic sleep_prev_reg, sleep_prev_next;
  logic master_clear_n_raw, bod_raw, osc_rise;

  // pin tied inactive inside when the select bit is zero
  assign master_clear_n_raw = CFG_IN.ext_reset_pin_select &&
                    !MASTER_CLEAR_N_IN;
  assign bod_raw = CFG_IN.brownout_enable_cfg &&
                   BROWNOUT_LOW_IN;
  assign osc_rise = OSC_INPUT_IN && !osc_prev_reg;

  always_comb begin
    master_clear_n_cnt_next = filt_step(master_clear_n_raw, master_clear_n_cnt_reg, MASTER_CLEAR_N_FILT);
    master_clear_n_low_next = (master_clear_n_cnt_next == MASTER_CLEAR_N_FILT);
    bod_cnt_next = filt_step(bod_raw, bod_cnt_reg, BOD_MIN);
    bod_trip_next = (bod_cnt_next == BOD_MIN);
    // once up, a falling supply is left to the brown-out detector
    por_seen_next = por_seen_reg || SUPPLY_GOOD_IN;
    osc_prev_next = OSC_INPUT_IN;
    sleep_prev_next = SLEEP_IN;
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      master_clear_n_cnt_reg <= '0;
      bod_cnt_reg <= '0;
      master_clear_n_low_reg <= 1'b0;
      bod_trip_reg <= 1'b0;
      por_seen_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
      sleep_prev_reg <= 1'b0;
    end else if (CE_IN) begin
      master_clear_n_cnt_reg <= master_clear_n_cnt_next;
      bod_cnt_reg <= bod_cnt_next;
      master_clear_n_low_reg <= master_clear_n_low_next;
      bod_trip_reg <= bod_trip_next;
      por_seen_reg <= por_seen_next;
      osc_prev_reg <= osc_prev_next;
      sleep_prev_reg <= sleep_prev_next;
    end
  end

  // sequencer state
  rtsq_pkg::rtsq_state_t state_reg, state_next;
  logic [`RTSQ_POWERUP_DELAY_TIMER_W-1:0] powerup_delay_timer_cnt_reg, powerup_delay_timer_cnt_next;
  logic [`RTSQ_OST_W-1:0] ost_cnt_reg, ost_cnt_next;
  logic pwr_kind_reg, pwr_kind_next;
  logic por_kind_reg, por_kind_next;
  logic wake_reg, wake_next;
  logic wake_pulse_next, core_run_next;
  rtsq_pkg::rtsq_cause_t cause_next;
  logic to_next, pd_next, por_flag_next;
  logic supply_ok, ost_needed, divided_clock_out_sel;

  assign supply_ok = por_seen_reg && !bod_trip_reg &&
    (!CFG_IN.brownout_enable_cfg || ABOVE_RELEASE_IN);
  assign ost_needed = is_crystal(CFG_IN.osc_mode) &&
                      (por_kind_reg || wake_reg);

  always_comb begin
    state_next = state_reg;
    powerup_delay_timer_cnt_next = '0;
    ost_cnt_next = '0;
    pwr_kind_next = pwr_kind_reg;
    por_kind_next = por_kind_reg;
    wake_next = wake_reg;
    wake_pulse_next = 1'b0;
    cause_next = RESET_CAUSE_OUT;
    to_next = WATCHDOG_EXPIRED_FLAG_OUT;
    pd_next = SLEEP_ENTERED_FLAG_OUT;
    // software set loses to nothing: only power-on clears the flag
    por_flag_next = POWER_ON_FLAG_OUT || POR_FLAG_SET_IN;
    unique case (state_reg)
      rtsq_pkg::RTSQ_ST_RUN: begin
        if (SLEEP_IN && !sleep_prev_reg) begin
          to_next = 1'b1;
          pd_next = 1'b0;
        end
        if (bod_trip_reg) begin
          state_next = rtsq_pkg::RTSQ_ST_HOLD;
          pwr_kind_next = 1'b1;
          por_kind_next = 1'b0;
          cause_next = '{brownout: 1'b1, default: 1'b0};
          to_next = 1'b1;
          pd_next = 1'b1;
        end else if (master_clear_n_low_reg) begin
          state_next = rtsq_pkg::RTSQ_ST_PIN;
          pwr_kind_next = 1'b0;
          por_kind_next = 1'b0;
          cause_next = '{pin_sleep: SLEEP_IN, pin_run: !SLEEP_IN,
                         default: 1'b0};
          if (SLEEP_IN) begin
            to_next = 1'b1;
            pd_next = 1'b0;
          end
        end else if (WDT_EXPIRE_IN && SLEEP_IN) begin
          to_next = 1'b0;
          pd_next = 1'b0;
          cause_next = '{wdt_sleep: 1'b1, default: 1'b0};
          // wake is a resumption: core reset stays released
          if (is_crystal(CFG_IN.osc_mode)) begin
            state_next = rtsq_pkg::RTSQ_ST_OST;
            wake_next = 1'b1;
          end else begin
            wake_pulse_next = 1'b1;
          end
        end else if (WDT_EXPIRE_IN) begin
          // internal only: the pin is an input and never driven
          state_next = rtsq_pkg::RTSQ_ST_PIN;
          pwr_kind_next = 1'b0;
          por_kind_next = 1'b0;
          cause_next = '{wdt_run: 1'b1, default: 1'b0};
          to_next = 1'b0;
        end
      end
      rtsq_pkg::RTSQ_ST_HOLD: begin
        if (supply_ok) begin
          if (pwr_kind_reg && !CFG_IN.powerup_delay_cfg)
            state_next = rtsq_pkg::RTSQ_ST_POWERUP_DELAY_TIMER;
          else if (ost_needed)
            state_next = rtsq_pkg::RTSQ_ST_OST;
          else
            state_next = rtsq_pkg::RTSQ_ST_PIN;
        end
      end
      rtsq_pkg::RTSQ_ST_POWERUP_DELAY_TIMER: begin
        // pin level ignored here so time-outs run from power-up
        if (!supply_ok) begin
          state_next = rtsq_pkg::RTSQ_ST_HOLD;
          cause_next = '{brownout: 1'b1, default: 1'b0};
        end else if (powerup_delay_timer_cnt_reg == POWERUP_DELAY_TIMER_LAST) begin
          state_next = ost_needed ? rtsq_pkg::RTSQ_ST_OST
                                  : rtsq_pkg::RTSQ_ST_PIN;
        end else begin
          powerup_delay_timer_cnt_next = powerup_delay_timer_cnt_reg + `RTSQ_POWERUP_DELAY_TIMER_W'(1);
        end
      end
      rtsq_pkg::RTSQ_ST_OST: begin
        ost_cnt_next = ost_cnt_reg;
        if (!supply_ok && !wake_reg) begin
          state_next = rtsq_pkg::RTSQ_ST_HOLD;
        end else if (osc_rise) begin
          if (ost_cnt_reg == OST_LAST) begin
            state_next = wake_reg ? rtsq_pkg::RTSQ_ST_RUN
                                  : rtsq_pkg::RTSQ_ST_PIN;
            wake_pulse_next = wake_reg;
            wake_next = 1'b0;
          end else begin
            ost_cnt_next = ost_cnt_reg + `RTSQ_OST_W'(1);
          end
        end
      end
      rtsq_pkg::RTSQ_ST_PIN: begin
        if (!supply_ok)
          state_next = rtsq_pkg::RTSQ_ST_HOLD;
        else if (!master_clear_n_low_reg)
          state_next = rtsq_pkg::RTSQ_ST_RUN;
      end
    endcase
    // reset-insensitive storage takes no reset from this block
    core_run_next = (state_next == rtsq_pkg::RTSQ_ST_RUN) ||
                    wake_next;
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_reg <= rtsq_pkg::RTSQ_ST_HOLD;
      powerup_delay_timer_cnt_reg <= '0;
      ost_cnt_reg <= '0;
      pwr_kind_reg <= 1'b1;
      por_kind_reg <= 1'b1;
      wake_reg <= 1'b0;
      CORE_RESET_N_OUT <= 1'b0;
      WAKE_RESUME_OUT <= 1'b0;
      RESET_CAUSE_OUT <= '{power_on: 1'b1, default: 1'b0};
      WATCHDOG_EXPIRED_FLAG_OUT <= `RTSQ_TO_RST;
      SLEEP_ENTERED_FLAG_OUT <= `RTSQ_PD_RST;
      POWER_ON_FLAG_OUT <= `RTSQ_POR_FLAG_RST;
    end else if (CE_IN) begin
      state_reg <= state_next;
      powerup_delay_timer_cnt_reg <= powerup_delay_timer_cnt_next;
      ost_cnt_reg <= ost_cnt_next;
      pwr_kind_reg <= pwr_kind_next;
      por_kind_reg <= por_kind_next;
      wake_reg <= wake_next;
      CORE_RESET_N_OUT <= core_run_next;
      WAKE_RESUME_OUT <= wake_pulse_next;
      RESET_CAUSE_OUT <= cause_next;
      WATCHDOG_EXPIRED_FLAG_OUT <= to_next;
      SLEEP_ENTERED_FLAG_OUT <= pd_next;
      POWER_ON_FLAG_OUT <= por_flag_next;
    end
  end

  // divided clock: free-running so a mode change glitches at most once
  logic [1:0] div_cnt_reg, div_cnt_next;
  logic div_out_next, div_oe_next;

  assign divided_clock_out_sel = (CFG_IN.osc_mode == rtsq_pkg::RTSQ_INTERNAL_OSC_DIVIDED_CLOCK_OUT)
                   || (CFG_IN.osc_mode == rtsq_pkg::RTSQ_RC_OSC_DIVIDED_CLOCK_OUT);

  always_comb begin
    div_cnt_next = div_cnt_reg + 2'h1;
    div_out_next = divided_clock_out_sel && div_cnt_next[1];
    div_oe_next = divided_clock_out_sel;
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      div_cnt_reg <= 2'h0;
      DIVIDED_CLOCK_OUT <= 1'b0;
      DIVIDED_CLOCK_OE_OUT <= 1'b0;
    end else if (CE_IN) begin
      div_cnt_reg <= div_cnt_next;
      DIVIDED_CLOCK_OUT <= div_out_next;
      DIVIDED_CLOCK_OE_OUT <= div_oe_next;
    end
  end

  chk_divided_clock_out_period: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (divided_clock_out_sel && CE_IN)[*4] |->
      DIVIDED_CLOCK_OUT != $past(DIVIDED_CLOCK_OUT, 2))
    else $error("divided clock does not toggle every two cycles");

  chk_wdt_cause: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    state_reg == rtsq_pkg::RTSQ_ST_RUN && CE_IN && WDT_EXPIRE_IN &&
      !SLEEP_IN && !bod_trip_reg && !master_clear_n_low_reg |=>
      RESET_CAUSE_OUT.wdt_run && !WATCHDOG_EXPIRED_FLAG_OUT &&
      !CORE_RESET_N_OUT)
    else $error("watchdog reset not recorded");

  chk_wake_no_reset: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    state_reg == rtsq_pkg::RTSQ_ST_RUN && CE_IN && WDT_EXPIRE_IN &&
      SLEEP_IN && !bod_trip_reg && !master_clear_n_low_reg |=>
      CORE_RESET_N_OUT && !SLEEP_ENTERED_FLAG_OUT)
    else $error("watchdog wake caused a reset");

  chk_pin_filter: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    $rose(master_clear_n_low_reg) |-> $past(master_clear_n_cnt_reg) == MASTER_CLEAR_N_FILT - 8'h01)
    else $error("pin reset accepted before filter time");

  chk_delay_restart: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    state_reg == rtsq_pkg::RTSQ_ST_POWERUP_DELAY_TIMER && CE_IN && !supply_ok |=>
      state_reg == rtsq_pkg::RTSQ_ST_HOLD && powerup_delay_timer_cnt_reg == '0)
    else $error("supply dip did not restart power-up delay");

  chk_delay_length: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    state_reg == rtsq_pkg::RTSQ_ST_POWERUP_DELAY_TIMER && CE_IN && supply_ok &&
      state_next != rtsq_pkg::RTSQ_ST_POWERUP_DELAY_TIMER |-> powerup_delay_timer_cnt_reg == POWERUP_DELAY_TIMER_LAST)
    else $error("power-up delay ended at wrong count");

  chk_ost_length: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    state_reg == rtsq_pkg::RTSQ_ST_OST && CE_IN && osc_rise &&
      (supply_ok || wake_reg) &&
      state_next != rtsq_pkg::RTSQ_ST_OST |-> ost_cnt_reg == OST_LAST)
    else $error("start-up count ended early");

  chk_release_clean: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    $rose(CORE_RESET_N_OUT) |-> $past(supply_ok) && !$past(master_clear_n_low_reg))
    else $error("core released while a reset source is active");

  chk_por_flag: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    $rose(POWER_ON_FLAG_OUT) |-> $past(POR_FLAG_SET_IN))
    else $error("power-on flag set without software");

  chk_bod_off: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (!CFG_IN.brownout_enable_cfg)[*2] |-> !bod_trip_reg)
    else $error("brown-out tripped while disabled");

endmodule // rtsq_sequencer

// *** dv/rtsq_far_model.sv ***
// far side of the sequencer: reset pin, supply monitors, oscillator
// assumes the bench steers it on rising edges of the system clock
`timescale 1ns/1ns
module rtsq_far_model (
  // steering
  input wire logic clk_in,
  input wire logic pin_low_in,
  input wire logic supply_ok_in,
  input wire logic dip_in,
  input wire logic osc_run_in,
  // pins and monitors
  output logic master_clear_n_out,
  output logic supply_good_out,
  output logic brownout_low_out,
  output logic above_release_out,
  output logic osc_out
);
  logic [1:0] osc_div_reg = 2'h0;
  // oscillator rises every fourth system clock, held low when stopped
  always_ff @(posedge clk_in) begin
    osc_div_reg <= osc_run_in ? osc_div_reg + 2'h1 : 2'h0;
  end
  assign osc_out = osc_div_reg[1];
  // pin held low as long as asked, also across time-outs
  assign master_clear_n_out = ~pin_low_in;
  assign supply_good_out = supply_ok_in;
  assign brownout_low_out = ~supply_ok_in | dip_in;
  assign above_release_out = supply_ok_in & ~dip_in;
endmodule // rtsq_far_model

// *** dv/tb.sv ***
// self-checking bench of the reset and time-out sequencer
// assumes the far-side model and a 125 MHz system clock
`timescale 1ns/1ns
module tb;
  localparam int PO = 0, WR = 1, WS = 2, PR = 3, PS = 4, BO = 5;
  localparam int S_WDT = 0, S_PIN = 1, S_SUP = 2, S_DIP = 3, S_SET = 4;
  logic clk = 1'b0, rst_n = 1'b0, wdt = 1'b0, slp = 1'b0, pset = 1'b0;
  logic ce = 1'b1, e_to = 1'b1;
  logic pin_low = 1'b0, sup_ok = 1'b0, dip = 1'b0, osc_run = 1'b0;
  logic [5:0] cfg = 6'h00;
  logic master_clear_n_n, sgood, bo_low, above, osc, core_n, wake, to_f, pd_f;
  logic por_f, dclk, dclk_oe;
  rtsq_pkg::rtsq_cause_t cause;
  int mismatches = 0, n_checks = 0, cyc = 0, n, lows = 0, t0;
  logic [31:0] seed = 32'h1d13cf9a;

  rtsq_far_model u_far (.clk_in(clk), .pin_low_in(pin_low),
    .supply_ok_in(sup_ok), .dip_in(dip), .osc_run_in(osc_run),
    .master_clear_n_out(master_clear_n_n), .supply_good_out(sgood),
    .brownout_low_out(bo_low), .above_release_out(above), .osc_out(osc));

  rtsq_sequencer #(.POWERUP_CYCLES(20)) u_dut (.CLK_IN(clk),
    .RST_N_IN(rst_n), .CE_IN(ce), .CFG_IN(rtsq_pkg::rtsq_cfg_t'(cfg)),
    .MASTER_CLEAR_N_IN(master_clear_n_n), .SUPPLY_GOOD_IN(sgood),
    .BROWNOUT_LOW_IN(bo_low), .ABOVE_RELEASE_IN(above),
    .OSC_INPUT_IN(osc), .WDT_EXPIRE_IN(wdt), .SLEEP_IN(slp),
    .POR_FLAG_SET_IN(pset), .CORE_RESET_N_OUT(core_n),
    .WAKE_RESUME_OUT(wake), .RESET_CAUSE_OUT(cause),
    .WATCHDOG_EXPIRED_FLAG_OUT(to_f), .SLEEP_ENTERED_FLAG_OUT(pd_f),
    .POWER_ON_FLAG_OUT(por_f), .DIVIDED_CLOCK_OUT(dclk),
    .DIVIDED_CLOCK_OE_OUT(dclk_oe));

  initial begin
    forever #4 clk = ~clk;
  end

  // hang guard, well above the longest expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      give_verdict();
    end
  end
  always @(negedge clk) begin
    if (core_n !== 1'b1) lows++;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
  endfunction
  function automatic int exp_time(input logic [5:0] c);
    return (c[3] ? 0 : 20) + (c[2:0] < 3'h3 ? 4096 : 0);
  endfunction

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp, input string m);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic chk_rng(input int v, input int lo, input int hi);
    n_checks++;
    if (v < lo || v > hi) begin
      mismatches++;
      $display("[FAIL] %0t delay %0d cycles", $time, v);
    end
  endtask
  task automatic chk_cause(input int k, input logic t, input logic p);
    n_checks++;
    if (cause !== 6'h20 >> k || to_f !== t || pd_f !== p) begin
      mismatches++;
      $display("[FAIL] %0t cause %b flags %b%b", $time, cause, to_f, pd_f);
    end
  endtask
  task automatic wait_up(input int lim);
    n = 0;
    @(negedge clk);
    while (core_n !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic put(input int s, input logic v);
    case (s)
      S_WDT: wdt <= v;
      S_PIN: pin_low <= v;
      S_SUP: sup_ok <= v;
      S_DIP: dip <= v;
      default: pset <= v;
    endcase
  endtask
  task automatic drive(input int s, input logic v, input int len);
    @(posedge clk);
    put(s, v);
    repeat (len) @(posedge clk);
    put(s, ~v);
    @(negedge clk);
  endtask
  task automatic power_up(input logic [5:0] c);
    @(posedge clk);
    rst_n <= 1'b0;
    cfg <= c;
    sup_ok <= 1'b0;
    osc_run <= 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (9) @(posedge clk);
    @(negedge clk);
    chk(core_n, 1'b0, "core left reset without supply");
    @(posedge clk);
    sup_ok <= 1'b1;
    wait_up(4300);
    chk_rng(n, exp_time(c) - 4, exp_time(c) + 8);
    chk_cause(PO, 1'b1, 1'b1);
    chk(por_f, 1'b0, "power-on flag");
  endtask
  task automatic wdt_pulse;
    drive(S_WDT, 1'b1, 1);
  endtask

  initial begin
    for (int m = 0; m < 8; m++) begin
      power_up({3'b110, m[2:0]});
      chk(dclk_oe, m == 5 || m == 7, "clock out enable");
      if (dclk_oe === 1'b1) begin
        @(posedge dclk);
        t0 = cyc;
        @(posedge dclk);
        chk_rng(cyc - t0, 4, 4);
      end
      if (m == 1) begin
        // crystal wake keeps the core running through the start-up count
        @(posedge clk);
        slp <= 1'b1;
        wdt_pulse();
        chk(core_n, 1'b1, "crystal wake reset registers");
        chk(wake, 1'b0, "wake before start-up count");
        t0 = cyc;
        @(posedge wake);
        chk_rng(cyc - t0, 4090, 4104);
        @(posedge clk);
        slp <= 1'b0;
      end
    end
    power_up(6'b011001);
    power_up(6'b001011);
    t0 = lows;
    drive(S_PIN, 1'b1, 40);
    drive(S_SUP, 1'b0, 20);
    chk_rng(lows - t0, 0, 0);
    power_up(6'b110111);
    drive(S_SET, 1'b1, 1);
    chk(por_f, 1'b1, "power-on flag set");
    // enable low freezes the block, so the watchdog goes unseen
    @(posedge clk);
    ce <= 1'b0;
    wdt_pulse();
    chk(core_n, 1'b1, "watchdog taken with enable low");
    @(posedge clk);
    ce <= 1'b1;
    // watchdog in run: low one cycle, pin untouched
    wdt_pulse();
    chk(core_n, 1'b0, "watchdog reset missing");
    chk_cause(WR, 1'b0, 1'b1);
    chk(master_clear_n_n, 1'b1, "pin pulled by watchdog");
    wait_up(6);
    chk_rng(n, 0, 2);
    chk(por_f, 1'b1, "power-on flag kept");
    drive(S_PIN, 1'b1, 40);
    chk(core_n, 1'b0, "pin reset missing");
    chk_cause(PR, 1'b0, 1'b1);
    wait_up(6);
    chk_rng(n, 0, 3);
    @(posedge clk);
    slp <= 1'b1;
    drive(S_PIN, 1'b1, 40);
    chk_cause(PS, 1'b1, 1'b0);
    wait_up(6);
    wdt_pulse();
    chk(wake, 1'b1, "no wake pulse");
    chk(core_n, 1'b1, "wake reset registers");
    chk(to_f, 1'b0, "wake expired flag");
    chk(pd_f, 1'b0, "wake sleep flag");
    chk_cause(WS, 1'b0, 1'b0);
    @(negedge clk);
    chk(wake, 1'b0, "wake pulse too long");
    @(posedge clk);
    slp <= 1'b0;
    t0 = lows;
    drive(S_DIP, 1'b1, 5);
    chk_rng(lows - t0, 0, 0);
    drive(S_DIP, 1'b1, 20);
    chk_cause(BO, 1'b1, 1'b1);
    wait_up(40);
    chk_rng(n, 20, 28);
    // short dip inside the delay: a restart shows as a full delay after it
    drive(S_DIP, 1'b1, 20);
    repeat (10) @(posedge clk);
    drive(S_DIP, 1'b1, 5);
    wait_up(40);
    chk_rng(n, 20, 28);
    chk(por_f, 1'b1, "power-on flag after brown-out");
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      t0 = lows;
      if (seed[5:4] == 2'h0) begin
        drive(S_PIN, 1'b1, 1 + int'(seed[3:0]));
        chk_rng(lows - t0, 0, 0);
      end else if (seed[5:4] == 2'h1) begin
        drive(S_PIN, 1'b1, 26 + int'(seed[3:0]));
        chk_cause(PR, e_to, 1'b1);
      end else begin
        wdt_pulse();
        e_to = 1'b0;
        chk_cause(WR, 1'b0, 1'b1);
      end
      wait_up(6);
      chk_rng(n, 0, 3);
    end
    // pin kept low across the whole time-out
    @(posedge clk);
    rst_n <= 1'b0;
    pin_low <= 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (60) @(posedge clk);
    pin_low <= 1'b0;
    @(negedge clk);
    chk(core_n, 1'b0, "released under held pin");
    wait_up(8);
    chk_rng(n, 0, 3);
    give_verdict();
  end
endmodule // tb
